//--- hdl/lane_map.sv
// splits a 16-bit per-lane control word into four source groups
// assumes bit order b0..b3, a0..a3, c3..c0, d3..d0
`timescale 1ns/1ps
module lane_map
(
    input wire logic [15:0] laneBits,
    output logic [3:0] srcA,
    output logic [3:0] srcB,
    output logic [3:0] srcC,
    output logic [3:0] srcD
);

    // ------------------------------------------------------------
    // per-lane wiring
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_lane
            // b and a run upward, c and d run downward
            assign srcB[i] = laneBits[i];
            assign srcA[i] = laneBits[4 + i];
            assign srcC[i] = laneBits[11 - i];
            assign srcD[i] = laneBits[15 - i];
        end
    endgenerate

endmodule

//--- hdl/tmds_cfg_pkg.sv
// constants for the link switch analog configuration bank
// assumes a 32-bit apb slave with 8-bit byte addresses
package tmds_cfg_pkg;

    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_RX_GATE = 6'h10; // input termination gate
    localparam logic [5:0] IDX_TERM_1 = 6'h11; // sources a and b termination
    localparam logic [5:0] IDX_TERM_2 = 6'h12; // sources c and d termination
    localparam logic [5:0] IDX_EQ_1 = 6'h13; // sources a and b equalizer
    localparam logic [5:0] IDX_EQ_2 = 6'h14; // sources c and d equalizer
    localparam logic [5:0] IDX_TX = 6'h20; // transmitter settings

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RX_GATE = 8'h01;
    localparam logic [7:0] RST_TERM = 8'h00;
    localparam logic [7:0] RST_EQ = 8'h00;
    localparam logic [7:0] RST_TX = 8'h03;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GATE_BIT = 0; // input termination gate
    localparam int TX_PREEMPH_LSB = 2; // pre-emphasis code, two bits
    localparam int TX_TERM_BIT = 1; // output termination on
    localparam int TX_CUR_BIT = 0; // output drive current select
    localparam logic [7:0] GATE_MASK = 8'h01; // writable gate bits
    localparam logic [7:0] TX_MASK = 8'h0f; // writable transmitter bits

    // ------------------------------------------------------------
    // bus handshake states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00, // waiting for an access phase
        ST_RESP = 2'b01 // answering with pready
    } bus_state_t;

endpackage

//--- hdl/tmds_switch_analog_config_regs.sv
// apb register bank driving the analog front-end controls
// assumes a single clock, synchronous apb master, async reset
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tmds_switch_analog_config_regs
    import tmds_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3:0] termConnectA,
    output logic [3:0] termConnectB,
    output logic [3:0] termConnectC,
    output logic [3:0] termConnectD,
    output logic [3:0] eqHighA,
    output logic [3:0] eqHighB,
    output logic [3:0] eqHighC,
    output logic [3:0] eqHighD,
    output logic [1:0] outPreemphLevel,
    output logic outTermOn,
    output logic outDriveCurrentSel
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] gate_reg; // input termination gate register
    logic [15:0] term_reg; // per-lane termination connect bits
    logic [15:0] eq_reg; // per-lane equalizer level bits
    logic [7:0] tx_reg; // transmitter settings register
    bus_state_t state_reg; // bus handshake state
    logic [15:0] termEff; // termination after the gate
    logic [3:0] tA, tB, tC, tD; // mapped termination groups
    logic [3:0] eA, eB, eC, eD; // mapped equalizer groups

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic aligned; // word aligned access
    logic hitGate, hitT1, hitT2, hitE1, hitE2, hitTx;
    logic mapped; // address names a register
    logic commit; // access completes at this edge
    logic [7:0] rdSel; // read value of addressed register

    assign aligned = (paddr[1:0] == 2'b00);
    assign hitGate = aligned && (paddr[7:2] == IDX_RX_GATE);
    assign hitT1 = aligned && (paddr[7:2] == IDX_TERM_1);
    assign hitT2 = aligned && (paddr[7:2] == IDX_TERM_2);
    assign hitE1 = aligned && (paddr[7:2] == IDX_EQ_1);
    assign hitE2 = aligned && (paddr[7:2] == IDX_EQ_2);
    assign hitTx = aligned && (paddr[7:2] == IDX_TX);
    assign mapped = hitGate | hitT1 | hitT2 | hitE1 | hitE2 | hitTx;
    // a write lands only on the edge where pready is seen high
    assign commit = psel && penable && pready;

    // read mux, unmapped addresses read zero
    always_comb
    begin
        rdSel = 8'h00;
        if (hitGate)
            rdSel = gate_reg & GATE_MASK;
        else if (hitT1)
            rdSel = term_reg[7:0];
        else if (hitT2)
            rdSel = term_reg[15:8];
        else if (hitE1)
            rdSel = eq_reg[7:0];
        else if (hitE2)
            rdSel = eq_reg[15:8];
        else if (hitTx)
            rdSel = tx_reg & TX_MASK;
    end

    // ------------------------------------------------------------
    // bus handshake, one wait state per access
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    // access phase seen: answer on the next edge
                    if (psel && penable)
                    begin
                        state_reg <= ST_RESP;
                        pready <= 1'b1;
                        pslverr <= ~mapped;
                        prdata <= pwrite ? 32'h0000_0000
                                         : {24'h00_0000, rdSel};
                    end
                end
                ST_RESP:
                begin
                    // release the answer after one cycle
                    state_reg <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gate_reg <= RST_RX_GATE;
            term_reg <= {RST_TERM, RST_TERM};
            eq_reg <= {RST_EQ, RST_EQ};
            tx_reg <= RST_TX;
        end
        else if (commit && pwrite)
        begin
            // reserved bits are kept at zero
            if (hitGate)
                gate_reg <= pwdata[7:0] & GATE_MASK;
            if (hitT1)
                term_reg[7:0] <= pwdata[7:0];
            if (hitT2)
                term_reg[15:8] <= pwdata[7:0];
            if (hitE1)
                eq_reg[7:0] <= pwdata[7:0];
            if (hitE2)
                eq_reg[15:8] <= pwdata[7:0];
            if (hitTx)
                tx_reg <= pwdata[7:0] & TX_MASK;
        end
    end

    // ------------------------------------------------------------
    // lane mapping
    // ------------------------------------------------------------
    // a cleared gate opens every input termination
    assign termEff = gate_reg[GATE_BIT] ? term_reg : 16'h0000;

    lane_map u_term_map
    (
        .laneBits(termEff),
        .srcA(tA),
        .srcB(tB),
        .srcC(tC),
        .srcD(tD)
    );

    lane_map u_eq_map
    (
        .laneBits(eq_reg),
        .srcA(eA),
        .srcB(eB),
        .srcC(eC),
        .srcD(eD)
    );

    // ------------------------------------------------------------
    // analog control outputs, registered
    // ------------------------------------------------------------
    // 1 connects, 0 disconnects each input termination
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            termConnectA <= 4'h0;
            termConnectB <= 4'h0;
            termConnectC <= 4'h0;
            termConnectD <= 4'h0;
        end
        else
        begin
            termConnectA <= tA;
            termConnectB <= tB;
            termConnectC <= tC;
            termConnectD <= tD;
        end
    end

    // 1 selects 12 dB, 0 selects 6 dB per lane
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            eqHighA <= 4'h0;
            eqHighB <= 4'h0;
            eqHighC <= 4'h0;
            eqHighD <= 4'h0;
        end
        else
        begin
            eqHighA <= eA;
            eqHighB <= eB;
            eqHighC <= eC;
            eqHighD <= eD;
        end
    end

    // shared transmitter controls for all output lanes
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            outPreemphLevel <= RST_TX[TX_PREEMPH_LSB +: 2];
            outTermOn <= RST_TX[TX_TERM_BIT];
            outDriveCurrentSel <= RST_TX[TX_CUR_BIT];
        end
        else
        begin
            outPreemphLevel <= tx_reg[TX_PREEMPH_LSB +: 2];
            outTermOn <= tx_reg[TX_TERM_BIT];
            outDriveCurrentSel <= tx_reg[TX_CUR_BIT];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_term_connect;
        @(posedge clk) disable iff (reset)
        (gate_reg[GATE_BIT] && term_reg[4]) |=> termConnectA[0];
    endproperty
    a_term_connect: assert property (p_term_connect)
        else $error("set termination bit did not connect lane");

    property p_term_map;
        @(posedge clk) disable iff (reset)
        gate_reg[GATE_BIT] |=> (termConnectB == $past(term_reg[3:0]))
            && (termConnectC[3] == $past(term_reg[8]))
            && (termConnectD[0] == $past(term_reg[15]));
    endproperty
    a_term_map: assert property (p_term_map)
        else $error("termination lane mapping wrong");

    property p_eq_level;
        @(posedge clk) disable iff (reset)
        ##1 (eqHighA[0] == $past(eq_reg[4]));
    endproperty
    a_eq_level: assert property (p_eq_level)
        else $error("equalizer level does not follow its bit");

    property p_eq_map;
        @(posedge clk) disable iff (reset)
        ##1 (eqHighC[0] == $past(eq_reg[11]))
            && (eqHighD[3] == $past(eq_reg[12]))
            && (eqHighB == $past(eq_reg[3:0]));
    endproperty
    a_eq_map: assert property (p_eq_map)
        else $error("equalizer lane mapping wrong");

    property p_preemph;
        @(posedge clk) disable iff (reset)
        (commit && pwrite && hitTx) |=> ##1
            (outPreemphLevel == $past(pwdata[3:2], 2));
    endproperty
    a_preemph: assert property (p_preemph)
        else $error("pre-emphasis code not applied two cycles on");

    property p_out_term;
        @(posedge clk) disable iff (reset)
        $changed(tx_reg[TX_TERM_BIT]) |=> $changed(outTermOn);
    endproperty
    a_out_term: assert property (p_out_term)
        else $error("output termination did not follow its bit");

    property p_out_cur;
        @(posedge clk) disable iff (reset)
        ##1 (outDriveCurrentSel == $past(tx_reg[TX_CUR_BIT]));
    endproperty
    a_out_cur: assert property (p_out_cur)
        else $error("output current select wrong");

    property p_gate_open;
        @(posedge clk) disable iff (reset)
        !gate_reg[GATE_BIT] |=> ({termConnectA, termConnectB,
            termConnectC, termConnectD} == 16'h0000);
    endproperty
    a_gate_open: assert property (p_gate_open)
        else $error("termination connected while gate cleared");

    property p_readback;
        @(posedge clk) disable iff (reset)
        (commit && !pwrite && hitT1) |-> (prdata == {24'h00_0000,
            term_reg[7:0]});
    endproperty
    a_readback: assert property (p_readback)
        else $error("read data differs from register");

endmodule

//--- verif/tb.sv
// self-checking bench for the analog configuration register bank
// assumes the bank sits alone on an apb bus driven from this bench
`timescale 1ns/1ps
module tb
    import tmds_cfg_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0; // 20 MHz bus clock
    logic reset = 1'b1; // async reset, active high
    logic psel = 1'b0; // apb select
    logic penable = 1'b0; // apb access phase
    logic pwrite = 1'b0; // apb direction
    logic [7:0] paddr = 8'h00; // apb byte address
    logic [31:0] pwdata = 32'h0; // apb write data
    logic [31:0] prdata; // read data
    logic pready; // slave answer
    logic pslverr; // slave error
    logic [3:0] tA, tB, tC, tD; // termination connect per source
    logic [3:0] eA, eB, eC, eD; // equalizer high per source
    logic [1:0] preemph; // output pre-emphasis code
    logic outTerm; // output termination on
    logic curSel; // output drive current select
    int errors = 0; // mismatches seen
    int nCompared = 0; // comparisons made
    logic [31:0] rdat; // data of the last read
    logic err; // error flag of the last transfer
    logic [15:0] v; // walking lane pattern
    // register byte addresses
    localparam logic [7:0] GATE = {IDX_RX_GATE, 2'b00};
    localparam logic [7:0] T1 = {IDX_TERM_1, 2'b00};
    localparam logic [7:0] T2 = {IDX_TERM_2, 2'b00};
    localparam logic [7:0] E1 = {IDX_EQ_1, 2'b00};
    localparam logic [7:0] E2 = {IDX_EQ_2, 2'b00};
    localparam logic [7:0] TX = {IDX_TX, 2'b00};

    tmds_switch_analog_config_regs u_tmds_switch_analog_config_regs
    (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .termConnectA(tA), .termConnectB(tB), .termConnectC(tC),
        .termConnectD(tD), .eqHighA(eA), .eqHighB(eB), .eqHighC(eC),
        .eqHighD(eD), .outPreemphLevel(preemph), .outTermOn(outTerm),
        .outDriveCurrentSel(curSel)
    );

    // clock, 50 ns period
    initial
    begin
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 50)
            errors++;
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // let the analog outputs follow the register
    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    // expected per-source lanes {A, B, C, D} from a 16-bit word
    function automatic logic [15:0] lanes(input logic [15:0] b);
        return {b[7:4], b[3:0], b[8], b[9], b[10], b[11],
                b[12], b[13], b[14], b[15]};
    endfunction

    // verdict and end of run
    task automatic final_report();
        $display("compared %0d, errors %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // watchdog, far beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // reset state of the outputs and registers
        settle();
        check({preemph, outTerm, curSel}, 32'h3);
        check({tA, tB, tC, tD, eA, eB, eC, eD}, 32'h0);
        xfer(1'b0, TX, 32'h0);
        check(rdat, 32'h3);
        xfer(1'b0, GATE, 32'h0);
        check(rdat, 32'h1);
        // walking one through termination, walking zero through eq
        for (int i = 0; i < 16; i++)
        begin
            v = 16'h1 << i;
            xfer(1'b1, T1, {24'h0, v[7:0]});
            xfer(1'b1, T2, {24'h0, v[15:8]});
            xfer(1'b1, E1, {24'h0, ~v[7:0]});
            xfer(1'b1, E2, {24'h0, ~v[15:8]});
            settle();
            check({tA, tB, tC, tD}, lanes(v));
            check({eA, eB, eC, eD}, lanes(~v));
            xfer(1'b0, T2, 32'h0);
            check(rdat, {24'h0, v[15:8]});
            xfer(1'b0, E1, 32'h0);
            check(rdat, {24'h0, ~v[7:0]});
        end
        // gate cleared opens every lane, lane bits are kept
        xfer(1'b1, T1, 32'hff);
        xfer(1'b1, T2, 32'hff);
        xfer(1'b1, GATE, 32'h0);
        settle();
        check({tA, tB, tC, tD}, 32'h0);
        xfer(1'b0, T1, 32'h0);
        check(rdat, 32'hff);
        xfer(1'b1, GATE, 32'h1);
        settle();
        check({tA, tB, tC, tD}, 32'hffff);
        // every transmitter setting
        for (int i = 0; i < 16; i++)
        begin
            xfer(1'b1, TX, i);
            check(err, 1'b0);
            settle();
            check(preemph, i[3:2]);
            check(outTerm, i[1]);
            check(curSel, i[0]);
            xfer(1'b0, TX, 32'h0);
            check(rdat, i);
        end
        // reserved transmitter bits stay zero
        xfer(1'b1, TX, 32'hf0);
        xfer(1'b0, TX, 32'h0);
        check(rdat, 32'h0);
        // unmapped and unaligned addresses are refused
        xfer(1'b1, 8'h3c, 32'hff);
        check(err, 1'b1);
        xfer(1'b0, 8'h3c, 32'h0);
        check(err, 1'b1);
        check(rdat, 32'h0);
        xfer(1'b1, 8'h81, 32'h0f);
        check(err, 1'b1);
        xfer(1'b0, TX, 32'h0);
        check(err, 1'b0);
        check(rdat, 32'h0);
        final_report();
    end
endmodule
